/* core/ea_defs.svh */
// Constants for the effective-address generator and stop-entry logic
// Assumes inclusion by bare name from core design files
`ifndef EA_DEFS_SVH
`define EA_DEFS_SVH
`define PC_RESET_VAL     16'h0000
`define PC_STEP_ONE      16'h0001
`define PC_STEP_TWO      16'h0002
`define PC_STEP_THREE    16'h0003
`define CCR_I_BIT        3
`define CCR_C_BIT        0
`define CCR_RESET_VAL    8'h08
`define VEC_RESET        16'hfffe
`define VEC_EXT1         16'hfffa
`define VEC_EXT2         16'hfff8
`define VEC_KEYBOARD     16'hfff6
`endif

/* core/ea_pkg.sv */
// Types shared by the address generator files
// Assumes nothing beyond a SystemVerilog compiler
package ea_pkg;
  typedef enum logic [3:0] {
    MODE_INHERENT,
    MODE_IMMEDIATE,
    MODE_DIRECT,
    MODE_EXTENDED,
    MODE_INDEXED0,
    MODE_INDEXED8,
    MODE_INDEXED16,
    MODE_RELATIVE,
    MODE_BIT_SET_CLR,
    MODE_BIT_TEST_BR
  } addr_mode_t;
  typedef enum logic [2:0] {
    WAKE_NONE,
    WAKE_RESET,
    WAKE_EXT1,
    WAKE_EXT2,
    WAKE_KEYBOARD
  } wake_src_t;
endpackage

/* core/ea_calc.sv */
// Combinational effective-address and next-counter calculator
// Assumes operand bytes already fetched and stable
`timescale 1ns/1ps
`default_nettype none
`include "ea_defs.svh"
module ea_calc (
  input  wire ea_pkg::addr_mode_t mode,
  input  wire logic [15:0]        program_counter,
  input  wire logic [7:0]         byte1,
  input  wire logic [7:0]         byte2,
  input  wire logic [7:0]         index_reg,
  input  wire logic               branch_cond,
  output logic [15:0]             effective_address,
  output logic [15:0]             pc_next
);
  // Sign extension before adding, offsets are two's complement
  function automatic logic [15:0] sext(input logic [7:0] v);
    sext = {{8{v[7]}}, v};
  endfunction
  logic [8:0] low_sum;
  // Mode dispatch
  always_comb begin
    low_sum = 9'h000;
    effective_address = 16'h0000;
    pc_next = program_counter + `PC_STEP_ONE;
    case (mode)
      ea_pkg::MODE_INHERENT: begin
        effective_address = program_counter; // No operand fetched
      end
      ea_pkg::MODE_IMMEDIATE: begin
        effective_address = program_counter + `PC_STEP_ONE;
        pc_next = program_counter + `PC_STEP_TWO;
      end
      ea_pkg::MODE_DIRECT: begin
        effective_address = {8'h00, byte1};
        pc_next = program_counter + `PC_STEP_TWO;
      end
      ea_pkg::MODE_EXTENDED: begin
        effective_address = {byte1, byte2};
        pc_next = program_counter + `PC_STEP_THREE;
      end
      ea_pkg::MODE_INDEXED0: begin
        effective_address = {8'h00, index_reg};
      end
      ea_pkg::MODE_INDEXED8: begin
        low_sum = {1'b0, index_reg} + {1'b0, byte1};
        effective_address = {7'h00, low_sum}; // Carry is the high byte
        pc_next = program_counter + `PC_STEP_TWO;
      end
      ea_pkg::MODE_INDEXED16: begin
        low_sum = {1'b0, index_reg} + {1'b0, byte2};
        effective_address = {byte1 + {7'h00, low_sum[8]}, low_sum[7:0]};
        pc_next = program_counter + `PC_STEP_THREE;
      end
      ea_pkg::MODE_RELATIVE: begin
        effective_address = program_counter + `PC_STEP_TWO + sext(byte1);
        pc_next = branch_cond ? effective_address : program_counter + `PC_STEP_TWO;
      end
      ea_pkg::MODE_BIT_SET_CLR: begin
        effective_address = {8'h00, byte1};
        pc_next = program_counter + `PC_STEP_TWO;
      end
      ea_pkg::MODE_BIT_TEST_BR: begin
        effective_address = {8'h00, byte1}; // Test byte address
        pc_next = branch_cond ? program_counter + `PC_STEP_THREE + sext(byte2)
                              : program_counter + `PC_STEP_THREE;
      end
      default: begin
        effective_address = program_counter;
      end
    endcase
  end
endmodule
`default_nettype wire

/* core/wake_arb.sv */
// Stop-mode wake source arbiter and vector select
// Assumes pin requests already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
`include "ea_defs.svh"
module wake_arb (
  input  wire logic        reset_req,
  input  wire logic        ext1_req,
  input  wire logic        ext2_req,
  input  wire logic        key_req,
  output var ea_pkg::wake_src_t source,
  output logic [15:0]      vector
);
  // Reset first, then pins in fixed priority
  always_comb begin
    source = ea_pkg::WAKE_NONE;
    vector = `VEC_RESET;
    if (reset_req) begin
      source = ea_pkg::WAKE_RESET;
      vector = `VEC_RESET;
    end else if (ext1_req) begin
      source = ea_pkg::WAKE_EXT1;
      vector = `VEC_EXT1;
    end else if (ext2_req) begin
      source = ea_pkg::WAKE_EXT2;
      vector = `VEC_EXT2;
    end else if (key_req) begin
      source = ea_pkg::WAKE_KEYBOARD;
      vector = `VEC_KEYBOARD;
    end
  end
endmodule
`default_nettype wire

/* core/addr_mode_ea_and_stop_entry.sv */
// Effective-address sequencing and stop-mode entry/exit for the CPU core
// Assumes the fetch unit presents opcode bytes with instr_valid, and
// memory returns test bytes as test_data in the same cycle
// Operation
// - Inherent: opcode alone, no operand bytes, one-byte instruction
// - Immediate: operand at counter plus one, counter advances two
// - Direct: high address zero, low from next byte, counter plus two
// - Extended: address from two following bytes, high first, counter plus three
// - Indexed no offset: index on low byte, high zero, counter plus one
// - Indexed 8-bit: unsigned index plus byte, carry is high byte, plus two
// - Indexed 16-bit: index plus low offset, carry into high offset, plus three
// - Relative: taken gives counter plus two plus offset, else plus two
// - Bit set/clear: opcode bit number, direct target, change only that bit
// - Bit branch: test chosen bit for chosen state, branch plus three plus offset
// - Bit branch copies tested bit into carry flag, taken or not
// - Stop turns internal clock off, halting CPU, timer, serial, tone
// - Stop entry clears interrupt mask, leaves interrupt enables alone
// - While stopped, registers, memory and lines keep their values
// - Stop exits on either external pin, keyboard, or any reset
// - On exit counter loads the vector of the waking source
`timescale 1ns/1ps
`default_nettype none
`include "ea_defs.svh"
module addr_mode_ea_and_stop_entry #(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              instr_valid,
  input  wire ea_pkg::addr_mode_t mode,
  input  wire logic [7:0]        opcode,
  input  wire logic [7:0]        byte1,
  input  wire logic [7:0]        byte2,
  input  wire logic [7:0]        index_reg,
  input  wire logic              branch_cond,
  input  wire logic [7:0]        test_data,
  input  wire logic              stop_instr,
  input  wire logic              ext_interrupt_pin1_n,
  input  wire logic              ext_interrupt_pin2_n,
  input  wire logic              keyboard_irq,
  input  wire logic              ext1_int_enable_in,
  input  wire logic              ext2_int_enable_in,
  input  wire logic              keyboard_int_enable_in,
  input  wire logic              ext_reset_n,
  input  wire logic              power_on_reset,
  output logic [ADDR_W-1:0]      effective_address,
  output logic [ADDR_W-1:0]      program_counter,
  output logic [7:0]             ccr,
  output logic [7:0]             bit_result,
  output logic                   bit_write,
  output logic                   internal_clk_en,
  output logic                   peripheral_halt,
  output logic                   stopped,
  output logic                   ext_int1_enable,
  output logic                   ext_int2_enable,
  output logic                   keyboard_int_enable
);
  // Pin synchronisers, first stage feeds only the second
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync1_d;
  always_comb begin
    sync1_d = {~ext_interrupt_pin1_n, ~ext_interrupt_pin2_n, keyboard_irq, ~ext_reset_n};
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync1_q;
    end
  end
  logic ext1_s;
  logic ext2_s;
  logic key_s;
  logic xrst_s;
  assign ext1_s = sync2_q[3];
  assign ext2_s = sync2_q[2];
  assign key_s  = sync2_q[1];
  assign xrst_s = sync2_q[0];

  // Bit test: opcode low bits pick bit, bit 0 picks wanted state
  logic [2:0] bit_num;
  logic       tested_bit;
  logic       bit_branch;
  assign bit_num    = opcode[3:1];
  assign tested_bit = test_data[bit_num];
  assign bit_branch = (tested_bit == ~opcode[0]);

  logic        cond_sel;
  logic [15:0] ea_w;
  logic [15:0] pc_w;
  assign cond_sel = (mode == ea_pkg::MODE_BIT_TEST_BR) ? bit_branch : branch_cond;

  ea_calc u_calc (
    .mode              (mode),
    .program_counter   (program_counter),
    .byte1             (byte1),
    .byte2             (byte2),
    .index_reg         (index_reg),
    .branch_cond       (cond_sel),
    .effective_address (ea_w),
    .pc_next           (pc_w)
  );

  ea_pkg::wake_src_t wake_src;
  logic [15:0]       wake_vec;
  logic              wake_any;
  wake_arb u_wake (
    .reset_req (xrst_s | power_on_reset),
    .ext1_req  (ext1_s),
    .ext2_req  (ext2_s),
    .key_req   (key_s),
    .source    (wake_src),
    .vector    (wake_vec)
  );
  assign wake_any = (wake_src != ea_pkg::WAKE_NONE);

  // Run/stop state
  typedef enum logic [0:0] {RUN, STOPPED} run_t;
  run_t        state_q;
  run_t        state_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [15:0] ea_q;
  logic [15:0] ea_d;
  logic [7:0]  ccr_q;
  logic [7:0]  ccr_d;
  logic [7:0]  res_q;
  logic [7:0]  res_d;
  logic        bw_q;
  logic        bw_d;
  logic [2:0]  en_q;
  logic [2:0]  en_d;

  // Next-state logic; nothing changes while stopped except the wake
  always_comb begin
    state_d = state_q;
    pc_d    = pc_q;
    ea_d    = ea_q;
    ccr_d   = ccr_q;
    res_d   = res_q;
    bw_d    = 1'b0;
    en_d    = en_q;
    case (state_q)
      RUN: begin
        // Not captured in the stop cycle, so entry leaves the enables alone
        if (!(instr_valid && stop_instr) &&
            en_q != {ext1_int_enable_in, ext2_int_enable_in, keyboard_int_enable_in}) begin
          en_d = {ext1_int_enable_in, ext2_int_enable_in, keyboard_int_enable_in};
        end
        if (instr_valid && stop_instr) begin
          state_d = STOPPED;
          ccr_d[`CCR_I_BIT] = 1'b0; // Enables unchanged
          pc_d = program_counter + `PC_STEP_ONE;
        end else if (instr_valid) begin
          ea_d = ea_w;
          pc_d = pc_w;
          if (mode == ea_pkg::MODE_BIT_TEST_BR) begin
            ccr_d[`CCR_C_BIT] = tested_bit;
          end
          if (mode == ea_pkg::MODE_BIT_SET_CLR) begin
            res_d = test_data;
            res_d[bit_num] = ~opcode[0]; // Only the chosen bit
            bw_d = 1'b1;
          end
        end
      end
      STOPPED: begin
        // Registers hold: no assignment other than wake
        if (wake_any) begin
          state_d = RUN;
          pc_d = wake_vec;
        end
      end
      default: begin
        state_d = RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= RUN;
      pc_q    <= `PC_RESET_VAL;
      ea_q    <= 16'h0000;
      ccr_q   <= `CCR_RESET_VAL;
      res_q   <= 8'h00;
      bw_q    <= 1'b0;
      en_q    <= 3'h0;
    end else begin
      state_q <= state_d;
      pc_q    <= pc_d;
      ea_q    <= ea_d;
      ccr_q   <= ccr_d;
      res_q   <= res_d;
      bw_q    <= bw_d;
      en_q    <= en_d;
    end
  end

  // Outputs all registered
  assign program_counter     = pc_q;
  assign effective_address   = ea_q;
  assign ccr                 = ccr_q;
  assign bit_result          = res_q;
  assign bit_write           = bw_q;
  assign stopped             = (state_q == STOPPED);
  assign internal_clk_en     = (state_q == RUN);
  assign peripheral_halt     = (state_q == STOPPED);
  assign ext_int1_enable     = en_q[2];
  assign ext_int2_enable     = en_q[1];
  assign keyboard_int_enable = en_q[0];

  // Instruction accepted and not a stop
  logic exec_ok;
  assign exec_ok = (state_q == RUN) && instr_valid && !stop_instr;

  stop_clears_mask_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == RUN && instr_valid && stop_instr) |=> (stopped && !ccr[`CCR_I_BIT]))
    else $error("stop entry did not clear mask");
  stop_keeps_en_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == RUN && instr_valid && stop_instr) |=> $stable(en_q))
    else $error("stop altered interrupt enables");
  stop_holds_pc_a: assert property (@(posedge clk) disable iff (rst)
    (stopped && !wake_any) |=> ($stable(pc_q) && $stable(ccr_q) && $stable(ea_q)))
    else $error("state changed while stopped");
  wake_exit_a: assert property (@(posedge clk) disable iff (rst)
    (stopped && wake_any) |=> (!stopped && pc_q == $past(wake_vec)))
    else $error("wake did not load vector");
  clock_off_a: assert property (@(posedge clk) disable iff (rst)
    internal_clk_en == !peripheral_halt)
    else $error("clock enable and halt disagree");
  direct_addr_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == RUN && instr_valid && !stop_instr && mode == ea_pkg::MODE_DIRECT)
    |=> (effective_address == {8'h00, $past(byte1)} && pc_q == $past(pc_q) + 16'h0002))
    else $error("direct mode address wrong");
  idx8_addr_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == RUN && instr_valid && !stop_instr && mode == ea_pkg::MODE_INDEXED8)
    |=> (effective_address == {8'h00, $past(index_reg)} + {8'h00, $past(byte1)}))
    else $error("indexed 8-bit address wrong");
  ext_addr_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == RUN && instr_valid && !stop_instr && mode == ea_pkg::MODE_EXTENDED)
    |=> (effective_address == {$past(byte1), $past(byte2)} && pc_q == $past(pc_q) + 16'h0003))
    else $error("extended mode address wrong");
  carry_copy_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == RUN && instr_valid && !stop_instr && mode == ea_pkg::MODE_BIT_TEST_BR)
    |=> (ccr[`CCR_C_BIT] == $past(tested_bit)))
    else $error("carry not copied from tested bit");
  rel_not_taken_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == RUN && instr_valid && !stop_instr && mode == ea_pkg::MODE_RELATIVE && !branch_cond)
    |=> (pc_q == $past(pc_q) + 16'h0002))
    else $error("untaken branch counter wrong");
  // Inherent: one byte, address is the opcode's own
  inherent_pc_a: assert property (@(posedge clk) disable iff (rst)
    (exec_ok && mode == ea_pkg::MODE_INHERENT)
    |=> (pc_q == $past(pc_q) + 16'h0001 && effective_address == $past(pc_q)))
    else $error("inherent counter wrong");
  // Immediate operand sits right after the opcode
  imm_addr_a: assert property (@(posedge clk) disable iff (rst)
    (exec_ok && mode == ea_pkg::MODE_IMMEDIATE)
    |=> (effective_address == $past(pc_q) + 16'h0001 && pc_q == $past(pc_q) + 16'h0002))
    else $error("immediate address wrong");
  // Index alone reaches only the first page
  idx0_addr_a: assert property (@(posedge clk) disable iff (rst)
    (exec_ok && mode == ea_pkg::MODE_INDEXED0)
    |=> (effective_address == {8'h00, $past(index_reg)} && pc_q == $past(pc_q) + 16'h0001))
    else $error("indexed plain address wrong");
  // Short indexed form is two bytes long
  idx8_pc_a: assert property (@(posedge clk) disable iff (rst)
    (exec_ok && mode == ea_pkg::MODE_INDEXED8)
    |=> (pc_q == $past(pc_q) + 16'h0002))
    else $error("indexed 8-bit counter wrong");
  // Long indexed carry ripples into the high byte
  idx16_addr_a: assert property (@(posedge clk) disable iff (rst)
    (exec_ok && mode == ea_pkg::MODE_INDEXED16)
    |=> (effective_address == {$past(byte1), $past(byte2)} + {8'h00, $past(index_reg)}
         && pc_q == $past(pc_q) + 16'h0003))
    else $error("indexed 16-bit address wrong");
  // Taken branch adds the sign-extended offset
  rel_taken_a: assert property (@(posedge clk) disable iff (rst)
    (exec_ok && mode == ea_pkg::MODE_RELATIVE && branch_cond)
    |=> (pc_q == $past(pc_q) + 16'h0002 + {{8{$past(byte1[7])}}, $past(byte1)}))
    else $error("taken branch counter wrong");
  // Other bits of the target byte pass through untouched
  bit_set_only_a: assert property (@(posedge clk) disable iff (rst)
    (exec_ok && mode == ea_pkg::MODE_BIT_SET_CLR)
    |=> (bit_write && (bit_result & ~(8'h01 << $past(bit_num))) == ($past(test_data) & ~(8'h01 << $past(bit_num)))))
    else $error("bit set disturbed other bits");
  // Chosen bit takes the opcode-selected level
  bit_value_a: assert property (@(posedge clk) disable iff (rst)
    (exec_ok && mode == ea_pkg::MODE_BIT_SET_CLR)
    |=> (bit_result[$past(bit_num)] == !$past(opcode[0])))
    else $error("bit set value wrong");
  // Bit branch target is three past the opcode plus offset
  bit_br_taken_a: assert property (@(posedge clk) disable iff (rst)
    (exec_ok && mode == ea_pkg::MODE_BIT_TEST_BR && bit_branch)
    |=> (pc_q == $past(pc_q) + 16'h0003 + {{8{$past(byte2[7])}}, $past(byte2)}))
    else $error("bit branch target wrong");
  // Untaken bit branch steps over all three bytes
  bit_br_skip_a: assert property (@(posedge clk) disable iff (rst)
    (exec_ok && mode == ea_pkg::MODE_BIT_TEST_BR && !bit_branch)
    |=> (pc_q == $past(pc_q) + 16'h0003))
    else $error("bit branch skip wrong");
  // Test byte is direct-addressed
  bit_addr_a: assert property (@(posedge clk) disable iff (rst)
    (exec_ok && mode == ea_pkg::MODE_BIT_TEST_BR)
    |=> (effective_address == {8'h00, $past(byte1)}))
    else $error("bit test address wrong");
  // Stop steps past its own byte, then halts
  stop_pc_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == RUN && instr_valid && stop_instr)
    |=> (pc_q == $past(pc_q) + 16'h0001 && !internal_clk_en && peripheral_halt))
    else $error("stop entry counter or clock wrong");
  // No memory write may leave a stopped core
  stopped_no_write_a: assert property (@(posedge clk) disable iff (rst)
    stopped |=> !bit_write)
    else $error("write while stopped");
  // Enables frozen while stopped
  stop_en_hold_a: assert property (@(posedge clk) disable iff (rst)
    (stopped && !wake_any) |=> $stable(en_q))
    else $error("enables changed while stopped");
  // Reset outranks every pin on wake
  wake_reset_a: assert property (@(posedge clk) disable iff (rst)
    (stopped && (xrst_s || power_on_reset)) |=> (pc_q == `VEC_RESET))
    else $error("reset wake vector wrong");
  // First pin wins when no reset is pending
  wake_ext1_a: assert property (@(posedge clk) disable iff (rst)
    (stopped && !xrst_s && !power_on_reset && ext1_s) |=> (pc_q == `VEC_EXT1))
    else $error("pin one wake vector wrong");
  // Keyboard alone is enough to wake
  wake_key_a: assert property (@(posedge clk) disable iff (rst)
    (stopped && key_s) |=> !stopped)
    else $error("keyboard did not wake");
endmodule
`default_nettype wire

/* verif/mem_model.sv */
// Byte memory model for the low 256 locations
// Assumes reads are combinational and writes land on the clock
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input  wire logic       clk,
  input  wire logic [7:0] addr,
  input  wire logic       wr,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  output logic [7:0]      rdata
);
  logic [7:0] mem_q [256];
  // Fixed pattern, so the bench can predict every byte
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem_q[i] = 8'(i) ^ 8'h5a;
    end
  end
  // Modified byte written back whole
  always @(posedge clk) begin
    if (wr) begin
      mem_q[waddr] <= wdata;
    end
  end
  assign rdata = mem_q[addr];
endmodule
`default_nettype wire

/* verif/addr_mode_ea_and_stop_entry_test.sv */
// Self-checking bench for the address generator and stop logic
// Assumes mem_model answers test bytes addressed by byte1
`timescale 1ns/1ps
`default_nettype none
`include "ea_defs.svh"
module addr_mode_ea_and_stop_entry_test;
  logic               clk, rst, iv, stp, p1_n, p2_n, kirq, e1, e2, ke, xrst_n, por, bc;
  ea_pkg::addr_mode_t md;
  logic [7:0]         op, b1, b2, x, td, ccr, bres;
  logic [15:0]        ea, pc, pcm;
  logic               bw, cen, ph, stopped, o1, o2, ok;
  int                 n_fail, checks_done;
  logic [15:0]        vec [5];

  addr_mode_ea_and_stop_entry dut_u (
    .clk(clk), .rst(rst), .instr_valid(iv), .mode(md), .opcode(op), .byte1(b1), .byte2(b2),
    .index_reg(x), .branch_cond(bc), .test_data(td), .stop_instr(stp), .ext_interrupt_pin1_n(p1_n),
    .ext_interrupt_pin2_n(p2_n), .keyboard_irq(kirq), .ext1_int_enable_in(e1), .ext2_int_enable_in(e2),
    .keyboard_int_enable_in(ke), .ext_reset_n(xrst_n), .power_on_reset(por), .effective_address(ea),
    .program_counter(pc), .ccr(ccr), .bit_result(bres), .bit_write(bw), .internal_clk_en(cen),
    .peripheral_halt(ph), .stopped(stopped), .ext_int1_enable(o1), .ext_int2_enable(o2),
    .keyboard_int_enable(ok));
  mem_model mem_u (.clk(clk), .addr(b1), .wr(bw), .waddr(ea[7:0]), .wdata(bres), .rdata(td));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask

  // One instruction, presented for a single edge
  task automatic run(input ea_pkg::addr_mode_t m, input logic [7:0] o, a, b, input logic c);
    @(posedge clk);
    iv <= 1'b1;
    md <= m;
    op <= o;
    b1 <= a;
    b2 <= b;
    bc <= c;
    @(posedge clk);
    iv <= 1'b0;
    stp <= 1'b0;
    #1;
  endtask

  task automatic cp(input logic [15:0] e, s, input string w);
    chk(ea, e, w);
    pcm = pcm + s;
    chk(pc, pcm, w);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    pcm = 16'h0000;
  endtask

  task automatic t_modes();
    @(posedge clk);
    x <= 8'hff;
    run(ea_pkg::MODE_INHERENT, 8'h40, 8'h00, 8'h00, 1'b0);
    cp(pcm, 16'h0001, "inherent");
    run(ea_pkg::MODE_IMMEDIATE, 8'ha6, 8'h55, 8'h00, 1'b0);
    cp(pcm + 16'h0001, 16'h0002, "immediate");
    run(ea_pkg::MODE_DIRECT, 8'hb6, 8'hff, 8'h00, 1'b0);
    cp(16'h00ff, 16'h0002, "direct");
    run(ea_pkg::MODE_EXTENDED, 8'hc6, 8'h12, 8'h34, 1'b0);
    cp(16'h1234, 16'h0003, "extended");
    run(ea_pkg::MODE_INDEXED0, 8'hf6, 8'h77, 8'h00, 1'b0);
    cp(16'h00ff, 16'h0001, "index plain");
    run(ea_pkg::MODE_INDEXED8, 8'he6, 8'hff, 8'h00, 1'b0);
    cp(16'h01fe, 16'h0002, "index short");
    run(ea_pkg::MODE_INDEXED16, 8'hd6, 8'h12, 8'hf0, 1'b0);
    cp(16'h13ef, 16'h0003, "index long");
  endtask

  // Backward, forward and untaken branches
  task automatic t_rel();
    run(ea_pkg::MODE_RELATIVE, 8'h20, 8'h80, 8'h00, 1'b1);
    pcm = pcm + 16'hff80;
    chk(pc, pcm + 16'h0002, "branch back");
    run(ea_pkg::MODE_RELATIVE, 8'h20, 8'h7f, 8'h00, 1'b1);
    pcm = pcm + 16'h0081;
    chk(pc, pcm + 16'h0002, "branch fwd");
    run(ea_pkg::MODE_RELATIVE, 8'h20, 8'h7f, 8'h00, 1'b0);
    pcm = pcm + 16'h0004;
    chk(pc, pcm, "branch skip");
  endtask

  task automatic t_bits();
    logic [7:0] a;
    for (int i = 0; i < 8; i++) begin
      a = 8'h10 + 8'(i);
      run(ea_pkg::MODE_BIT_SET_CLR, {4'h1, 3'(i), 1'b0}, a, 8'h00, 1'b0);
      chk({8'h00, bres}, {8'h00, (a ^ 8'h5a) | (8'h01 << i)}, "bit set");
      chk({15'h0, bw}, 16'h0001, "write strobe");
      cp({8'h00, a}, 16'h0002, "bit set");
      a = 8'h20 + 8'(i);
      run(ea_pkg::MODE_BIT_SET_CLR, {4'h1, 3'(i), 1'b1}, a, 8'h00, 1'b0);
      chk({8'h00, bres}, {8'h00, (a ^ 8'h5a) & ~(8'h01 << i)}, "bit clear");
      cp({8'h00, a}, 16'h0002, "bit clear");
    end
    // Byte at 80 reads da: bit1 set, bit2 clear
    run(ea_pkg::MODE_BIT_TEST_BR, 8'h02, 8'h80, 8'h10, 1'b0);
    pcm = pcm + 16'h0013;
    chk(pc, pcm, "test set taken");
    chk({15'h0, ccr[0]}, 16'h0001, "carry one");
    run(ea_pkg::MODE_BIT_TEST_BR, 8'h04, 8'h80, 8'h10, 1'b1);
    pcm = pcm + 16'h0003;
    chk(pc, pcm, "test set skip");
    chk({15'h0, ccr[0]}, 16'h0000, "carry zero");
    run(ea_pkg::MODE_BIT_TEST_BR, 8'h05, 8'h80, 8'hfe, 1'b0);
    pcm = pcm + 16'h0001;
    chk(pc, pcm, "test clear taken");
  endtask

  // Stop, ignored traffic, then wake from source s
  task automatic t_stop(input int s);
    logic [15:0] e0;
    @(posedge clk);
    e1 <= 1'b1;
    e2 <= 1'b0;
    ke <= 1'b1;
    stp <= 1'b1;
    run(ea_pkg::MODE_INHERENT, 8'h8e, 8'h00, 8'h00, 1'b0);
    pcm = pcm + 16'h0001;
    e0 = ea;
    chk(pc, pcm, "stop pc");
    chk({13'h0, stopped, cen, ph}, 16'h0005, "stop state");
    chk({15'h0, ccr[`CCR_I_BIT]}, 16'h0000, "mask clear");
    chk({13'h0, o1, o2, ok}, 16'h0005, "enables kept");
    @(posedge clk);
    e1 <= 1'b0;
    run(ea_pkg::MODE_EXTENDED, 8'hc6, 8'hab, 8'hcd, 1'b0);
    chk(pc, pcm, "held pc");
    chk(ea, e0, "held ea");
    chk({15'h0, o1}, 16'h0001, "held enable");
    @(posedge clk);
    case (s)
      0: p1_n <= 1'b0;
      1: p2_n <= 1'b0;
      2: kirq <= 1'b1;
      3: xrst_n <= 1'b0;
      default: por <= 1'b1;
    endcase
    for (int i = 0; i < 8 && stopped !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk({15'h0, stopped}, 16'h0000, "woken");
    chk(pc, vec[s], "wake vector");
    @(posedge clk);
    {p1_n, p2_n, kirq, xrst_n, por} <= 5'b11010;
    repeat (4) @(posedge clk);
    do_reset();
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard, well past the expected run of under two hundred cycles
  initial begin
    #300000;
    n_fail++;
    give_verdict();
  end

  initial begin
    {rst, iv, stp, kirq, e1, e2, ke, por, bc} = '0;
    rst = 1'b1;
    {p1_n, p2_n, xrst_n} = 3'b111;
    md = ea_pkg::MODE_INHERENT;
    {op, b1, b2, x} = '0;
    vec = '{`VEC_EXT1, `VEC_EXT2, `VEC_KEYBOARD, `VEC_RESET, `VEC_RESET};
    n_fail = 0;
    checks_done = 0;
    do_reset();
    #1;
    chk({8'h00, ccr}, {8'h00, `CCR_RESET_VAL}, "reset ccr");
    t_modes();
    t_rel();
    t_bits();
    for (int s = 0; s < 5; s++) begin
      t_stop(s);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
